//--- common/net_led_pkg.sv
// Constants for the network status indicator encoder
package net_led_pkg;
	localparam int unsigned CLK_FREQ_HZ       = 250_000_000;
	localparam int unsigned FLASH_FREQ_HZ     = 2;
	// Half period of the 2 Hz pattern in clock cycles
	localparam int unsigned FLASH_HALF_CYCLES = CLK_FREQ_HZ / (FLASH_FREQ_HZ * 2);
	localparam int unsigned FLASH_CNT_W       = 26;
	// Traffic flicker: hold time started by a frame event; lit for the first half of it
	localparam int unsigned TRAFFIC_HOLD_MS   = 50;
	localparam int unsigned TRAFFIC_HOLD_CYCLES = (CLK_FREQ_HZ / 1000) * TRAFFIC_HOLD_MS;
	localparam int unsigned TRAFFIC_CNT_W     = 24;
	// Substitute cycle clock period when no network send clock is acquired
	localparam int unsigned SUBST_CYCLE_NS    = 1000000;
	localparam int unsigned SUBST_CYCLE_CYCLES = SUBST_CYCLE_NS / 4;
	localparam int unsigned SUBST_CNT_W       = 20;
	localparam int unsigned NUM_PORTS         = 3;
	localparam logic        LED_RESET         = 1'b0;

	typedef enum logic [1:0] {
		LOCK_OFF   = 2'b00,
		LOCK_SUBST = 2'b01,
		LOCK_PART  = 2'b11,
		LOCK_FULL  = 2'b10
	} lock_state_type;
endpackage

//--- hw/flash_divider.sv
// Shared 2 Hz flash square wave derived from the system clock
`timescale 1ns/1ns
`default_nettype none
module flash_divider (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Pattern
	output logic      flash_phase
);
	logic [net_led_pkg::FLASH_CNT_W-1:0] cnt_ff;
	logic [net_led_pkg::FLASH_CNT_W-1:0] nxt_cnt;
	logic                                phase_ff;
	logic                                nxt_phase;

	always_comb begin
		nxt_cnt   = cnt_ff + 1'b1;
		nxt_phase = phase_ff;
		if (cnt_ff == net_led_pkg::FLASH_CNT_W'(net_led_pkg::FLASH_HALF_CYCLES - 1)) begin
			nxt_cnt   = '0;
			nxt_phase = ~phase_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_ff   <= '0;
			phase_ff <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			phase_ff <= nxt_phase;
		end
	end

	assign flash_phase = phase_ff;
endmodule
`default_nettype wire

//--- hw/port_traffic_stretch.sv
// One port's link and traffic indicators
`timescale 1ns/1ns
`default_nettype none
module port_traffic_stretch (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Port status
	input  wire logic link_up,
	input  wire logic frame_seen,
	// Indicators
	output logic      port_link_led,
	output logic      port_traffic_led
);
	logic [net_led_pkg::TRAFFIC_CNT_W-1:0] hold_ff;
	logic [net_led_pkg::TRAFFIC_CNT_W-1:0] nxt_hold;
	logic                                  link_ff;
	logic                                  nxt_link;
	logic                                  act_ff;
	logic                                  nxt_act;

	always_comb begin
		nxt_link = link_up;
		nxt_hold = hold_ff;
		// Reload only after the hold expires; lit in the first half of each hold, dark in the second
		if (hold_ff != '0) begin
			nxt_hold = hold_ff - 1'b1;
		end else if (frame_seen) begin
			nxt_hold = net_led_pkg::TRAFFIC_CNT_W'(net_led_pkg::TRAFFIC_HOLD_CYCLES);
		end
		nxt_act = (hold_ff > net_led_pkg::TRAFFIC_CNT_W'(net_led_pkg::TRAFFIC_HOLD_CYCLES / 2));
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hold_ff <= '0;
			link_ff <= net_led_pkg::LED_RESET;
			act_ff  <= net_led_pkg::LED_RESET;
		end else begin
			hold_ff <= nxt_hold;
			link_ff <= nxt_link;
			act_ff  <= nxt_act;
		end
	end

	assign port_link_led    = link_ff;
	assign port_traffic_led = act_ff;
endmodule
`default_nettype wire

//--- hw/network_status_led_encoder.sv
// Network port, bus error and cycle lock indicator encoder
// Behaviour
// - Link indicator steady on while a partner is physically connected.
// - Traffic indicator flashes while frames are received or sent.
// - Bus error indicator dark when interface error-free and all exchange runs.
// - Bus error indicator steady on no link, wrong rate, or no full duplex.
// - Bus error flashes 2 Hz on device failure, unreachable device, bad configuration.
// - Cycle lock dark while unsynchronised or isochronous not configured.
// - Configured but unsynchronised: generate local substitute cycle clock.
// - Cycle lock steady when interface, tasks, drive and DP interfaces all synchronised.
// - Cycle lock flashes 2 Hz when drive/DP interfaces not yet synchronised.
// - Without isochronous configuration, no send-clock sync; cycle lock dark.
`timescale 1ns/1ns
`default_nettype none
module network_status_led_encoder (
	// Clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               reset_n,
	// Per-port physical state
	input  wire logic [net_led_pkg::NUM_PORTS-1:0]  port_link_up,
	input  wire logic [net_led_pkg::NUM_PORTS-1:0]  port_frame_seen,
	// Bus fault conditions
	input  wire logic                               no_subnet_link,
	input  wire logic                               wrong_rate,
	input  wire logic                               no_full_duplex,
	// IO device fault conditions
	input  wire logic                               io_device_failed,
	input  wire logic                               io_device_unreachable,
	input  wire logic                               config_bad,
	// Isochronous synchronisation
	input  wire logic                               iso_configured,
	input  wire logic                               send_clock_locked,
	input  wire logic                               send_clock_tick,
	input  wire logic                               task_synced,
	input  wire logic                               drive_dp_synced,
	// Indicators
	output logic [net_led_pkg::NUM_PORTS-1:0]       port_link_led,
	output logic [net_led_pkg::NUM_PORTS-1:0]       port_traffic_led,
	output logic                                    network_error_led,
	output logic                                    cycle_lock_led,
	// Cycle clock to task system and drive/DP interfaces
	output logic                                    cycle_tick,
	output logic                                    cycle_substitute
);
	logic                                 flash_phase;
	logic [net_led_pkg::NUM_PORTS-1:0]    link_led_w;
	logic [net_led_pkg::NUM_PORTS-1:0]    act_led_w;
	logic                                 err_ff;
	logic                                 nxt_err;
	logic                                 lock_led_ff;
	logic                                 nxt_lock_led;
	net_led_pkg::lock_state_type          lock_ff;
	net_led_pkg::lock_state_type          nxt_lock;
	logic [net_led_pkg::SUBST_CNT_W-1:0]  subst_cnt_ff;
	logic [net_led_pkg::SUBST_CNT_W-1:0]  nxt_subst_cnt;
	logic                                 tick_ff;
	logic                                 nxt_tick;
	logic                                 subst_ff;
	logic                                 nxt_subst;

	flash_divider u_flash (
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.flash_phase (flash_phase)
	);

	genvar g;
	generate
		for (g = 0; g < net_led_pkg::NUM_PORTS; g++) begin : g_port
			port_traffic_stretch u_port (
				.ref_clk          (ref_clk),
				.reset_n          (reset_n),
				.link_up          (port_link_up[g]),
				.frame_seen       (port_frame_seen[g]),
				.port_link_led    (link_led_w[g]),
				.port_traffic_led (act_led_w[g])
			);
		end
	endgenerate

	// Bus error: a hard bus fault outranks device faults
	always_comb begin
		if (no_subnet_link || wrong_rate || no_full_duplex) begin
			nxt_err = 1'b1;
		end else if (io_device_failed || io_device_unreachable || config_bad) begin
			nxt_err = flash_phase;
		end else begin
			nxt_err = 1'b0;
		end
	end

	// Synchronisation state
	always_comb begin
		nxt_lock = net_led_pkg::LOCK_OFF;
		if (!iso_configured) begin
			nxt_lock = net_led_pkg::LOCK_OFF;
		end else if (!send_clock_locked || !task_synced) begin
			nxt_lock = net_led_pkg::LOCK_SUBST;
		end else if (!drive_dp_synced) begin
			nxt_lock = net_led_pkg::LOCK_PART;
		end else begin
			nxt_lock = net_led_pkg::LOCK_FULL;
		end
		case (lock_ff)
			net_led_pkg::LOCK_OFF:   nxt_lock_led = 1'b0;
			net_led_pkg::LOCK_SUBST: nxt_lock_led = 1'b0;
			net_led_pkg::LOCK_PART:  nxt_lock_led = flash_phase;
			net_led_pkg::LOCK_FULL:  nxt_lock_led = 1'b1;
			default:                 nxt_lock_led = 1'b0;
		endcase
	end

	// Cycle clock: network tick when locked, local substitute when configured but unsynchronised, none when not configured
	always_comb begin
		nxt_subst_cnt = '0;
		nxt_tick      = 1'b0;
		nxt_subst     = 1'b0;
		case (lock_ff)
			net_led_pkg::LOCK_SUBST: begin
				nxt_subst = 1'b1;
				if (subst_cnt_ff ==
				    net_led_pkg::SUBST_CNT_W'(net_led_pkg::SUBST_CYCLE_CYCLES - 1)) begin
					nxt_subst_cnt = '0;
					nxt_tick      = 1'b1;
				end else begin
					nxt_subst_cnt = subst_cnt_ff + 1'b1;
				end
			end
			net_led_pkg::LOCK_PART, net_led_pkg::LOCK_FULL: begin
				nxt_tick = send_clock_tick;
			end
			// Not configured: the send clock is ignored altogether
			net_led_pkg::LOCK_OFF: nxt_tick = 1'b0;
			default:               nxt_tick = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			err_ff       <= net_led_pkg::LED_RESET;
			lock_led_ff  <= net_led_pkg::LED_RESET;
			lock_ff      <= net_led_pkg::LOCK_OFF;
			subst_cnt_ff <= '0;
			tick_ff      <= 1'b0;
			subst_ff     <= 1'b0;
		end else begin
			err_ff       <= nxt_err;
			lock_led_ff  <= nxt_lock_led;
			lock_ff      <= nxt_lock;
			subst_cnt_ff <= nxt_subst_cnt;
			tick_ff      <= nxt_tick;
			subst_ff     <= nxt_subst;
		end
	end

	assign port_link_led     = link_led_w;
	assign port_traffic_led  = act_led_w;
	assign network_error_led = err_ff;
	assign cycle_lock_led    = lock_led_ff;
	assign cycle_tick        = tick_ff;
	assign cycle_substitute  = subst_ff;
endmodule
`default_nettype wire

//--- sim/led_encoder_checker_assertions.sv
// Port-level checks for the network status indicator encoder
`timescale 1ns/1ns
`default_nettype none
module led_encoder_checker (
	// Clock and reset
	input wire logic	ref_clk,
	input wire logic	reset_n,
	// Port status
	input wire logic [2:0]	port_link_up,
	input wire logic [2:0]	port_frame_seen,
	// Faults
	input wire logic	no_subnet_link,
	input wire logic	wrong_rate,
	input wire logic	no_full_duplex,
	input wire logic	io_device_failed,
	input wire logic	io_device_unreachable,
	input wire logic	config_bad,
	// Synchronisation
	input wire logic	iso_configured,
	input wire logic	send_clock_locked,
	input wire logic	send_clock_tick,
	input wire logic	task_synced,
	input wire logic	drive_dp_synced,
	// Indicators and cycle clock
	input wire logic [2:0]	port_link_led,
	input wire logic [2:0]	port_traffic_led,
	input wire logic	network_error_led,
	input wire logic	cycle_lock_led,
	input wire logic	cycle_tick,
	input wire logic	cycle_substitute
);
	logic [1:0] age_ff;
	logic [1:0] nxt_age;
	wire bus = no_subnet_link | wrong_rate | no_full_duplex;
	wire devf = io_device_failed | io_device_unreachable | config_bad;
	wire sy = iso_configured && send_clock_locked && task_synced;
	// Hold checks off until pipelines hold post-reset values
	always_comb nxt_age = !reset_n ? 2'h0 : (age_ff == 2'h3 ? age_ff : age_ff + 2'h1);
	always_ff @(posedge ref_clk) age_ff <= nxt_age;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n || age_ff != 2'h3);
	chk_link_follow: assert property ($stable(port_link_up) |-> port_link_led == port_link_up)
		else $error("link indicator does not follow link state");
	chk_traffic_cause: assert property ($rose(port_traffic_led[0]) |-> $past(port_frame_seen[0], 2))
		else $error("traffic indicator lit without a frame");
	chk_err_dark: assert property (!bus && !devf |=> !network_error_led)
		else $error("error indicator lit without fault");
	chk_err_steady: assert property (bus |=> network_error_led)
		else $error("error indicator dark on bus fault");
	chk_flash_phase: assert property ((!bus && devf && sy && !drive_dp_synced)[*3] |-> network_error_led == cycle_lock_led)
		else $error("flash patterns out of phase");
	chk_lock_unsync: assert property (iso_configured && !send_clock_locked |-> ##2 !cycle_lock_led)
		else $error("lock indicator lit while unsynchronised");
	chk_subst_on: assert property ((iso_configured && !(send_clock_locked && task_synced))[*3] |-> cycle_substitute)
		else $error("substitute clock missing");
	chk_tick_pass: assert property (sy[*2] ##0 send_clock_tick |-> ##1 cycle_tick)
		else $error("send cycle tick not passed on");
	chk_lock_full: assert property (sy && drive_dp_synced |-> ##2 cycle_lock_led)
		else $error("lock indicator dark when fully synchronised");
	chk_no_iso: assert property ((!iso_configured)[*3] |-> !cycle_substitute && !cycle_lock_led)
		else $error("cycle activity without isochronous setup");
endmodule
bind network_status_led_encoder led_encoder_checker chk (.*);
`default_nettype wire

//--- sim/network_peer.sv
// Far-side network model: random frame events and send-cycle ticks
`timescale 1ns/1ns
`default_nettype none
module network_peer #(parameter int PERIOD = 16) (
	input  wire logic	ref_clk,
	input  wire logic	run,
	output logic [2:0]	frame_seen = 3'h0,
	output logic		cycle_pulse = 1'b0
);
	int cnt = 0;
	always @(posedge ref_clk) begin
		cnt <= (cnt + 1) % PERIOD;
		cycle_pulse <= #1 run && cnt == 0;
		frame_seen <= #1 run ? 3'($urandom) & 3'($urandom) : 3'h0;
	end
endmodule
`default_nettype wire

//--- sim/network_status_led_encoder_test.sv
// Self-checking bench for the network status indicator encoder
`timescale 1ns/1ns
`default_nettype none
module network_status_led_encoder_test;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic run = 1'b0;
	logic tick, err_led, lock_led, cyc_tick, subst;
	logic [2:0] link_up = 3'h0, bus_f = 3'h0, dev_f = 3'h0, frames, seen = 3'h0;
	logic [2:0] link_led, trf_led;
	logic [3:0] sy = 4'h0;
	logic [8:0] exp_q[$];
	int failures = 0, n_checks = 0, cycles = 0;
	event probe;
	network_status_led_encoder uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.port_link_up(link_up), .port_frame_seen(frames), .no_subnet_link(bus_f[0]),
		.wrong_rate(bus_f[1]), .no_full_duplex(bus_f[2]), .io_device_failed(dev_f[0]),
		.io_device_unreachable(dev_f[1]), .config_bad(dev_f[2]), .iso_configured(sy[3]),
		.send_clock_locked(sy[2]), .send_clock_tick(tick), .task_synced(sy[1]),
		.drive_dp_synced(sy[0]), .port_link_led(link_led), .port_traffic_led(trf_led),
		.network_error_led(err_led), .cycle_lock_led(lock_led), .cycle_tick(cyc_tick),
		.cycle_substitute(subst));
	network_peer peer (.ref_clk(ref_clk), .run(run), .frame_seen(frames), .cycle_pulse(tick));
	initial forever #2 ref_clk = ~ref_clk;
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [8:0] s, input logic [8:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected leds: expected %h seen %h", e, s);
		end
	endtask
	// Expected indicators: link, traffic, then {error, lock, substitute}
	task automatic step(input logic [2:0] b, d, input logic [3:0] s, input logic [2:0] e);
		bus_f = b;
		dev_f = d;
		sy = s;
		link_up = 3'($urandom);
		repeat (3) @(posedge ref_clk);
		#1 exp_q.push_back({link_up, seen, e});
		-> probe;
	endtask
	always @(probe) check({link_led, trf_led, err_led, lock_led, subst}, exp_q.pop_front());
	// Run is a few hundred cycles; ceiling leaves wide margin
	always @(posedge ref_clk) begin
		seen <= seen | frames;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'he7b6c3bf));
		repeat (12) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		for (int i = 0; i < 3; i++) step(3'h1 << i, 3'h0, 4'h0, 3'h4);
		step(3'h0, 3'h0, 4'h0, 3'h0);
		for (int i = 0; i < 3; i++) step(3'h0, 3'h1 << i, 4'h0, 3'h0);
		step(3'h7, 3'h7, 4'h0, 3'h4);
		$display("test error indicator done");
		step(3'h0, 3'h0, 4'h7, 3'h0);
		step(3'h0, 3'h0, 4'h8, 3'h1);
		step(3'h0, 3'h0, 4'hc, 3'h1);
		step(3'h0, 3'h0, 4'hb, 3'h1);
		step(3'h0, 3'h0, 4'hf, 3'h2);
		step(3'h0, 3'h1, 4'he, 3'h0);
		$display("test cycle lock done");
		reset_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 exp_q.push_back(9'h000);
		-> probe;
		@(posedge ref_clk);
		#1 reset_n = 1'b1;
		step(3'h0, 3'h0, 4'hf, 3'h2);
		run = 1'b1;
		repeat (200) @(posedge ref_clk);
		#1 run = 1'b0;
		step(3'h0, 3'h0, 4'hf, 3'h2);
		$display("test traffic done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
